// *** ocr_top.sv ***
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "ocr_cfg.svh"
// Overview of operation
// - Converter bit 2 high stops main oscillator, with safeguard only
// - Software stop switches core to auxiliary clock
// - Clearing bit or any reset restarts main
// - Wait startup plus instruction before main takeover
// - Aux starts within period after missing edge
// - Core runs normally from auxiliary clock
// - Power-up delay counted on the selected core clock source
// - Auxiliary oscillator stops once main runs
// - Other converter bits go to converter
// - Safeguard is fixed option, gates auxiliary
// - Safeguard drops edges above maximum frequency
// - Divider select gives 1, 2, 4, 4
// - Divider register resets zero, write only
// - Four reset sources: pin, power, watchdog, voltage
// - Pin active low, extended, held while low
// - Run/wait reset restarts oscillator, then initialises
// - Stop reset starts oscillator, then initialises
// - Internal clock divided 12 peripherals, 13 core
// - Internal reset sources drive pin low
module ocr_top
  import ocr_pkg::*;
#(
  parameter bit SAFEGUARD_EN = 1'b1,
  parameter int AUX_CYC = `OCR_AUX_PERIOD_NS / `OCR_CLK_PERIOD_NS,
  parameter int STARTUP_CYC = `OCR_OSC_STARTUP_NS / `OCR_CLK_PERIOD_NS,
  parameter int RST_DLY_TICKS = `OCR_RST_DLY_TICKS
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic main_osc_i,
  input wire logic stop_mode_i,
  input wire logic rst_pin_n_i,
  input wire logic por_i,
  input wire logic wdg_timeout_i,
  input wire logic low_voltage_detect_i,
  output logic main_osc_en_o,
  output logic aux_osc_en_o,
  output logic on_aux_o,
  output logic int_clk_tick_o,
  output logic periph_tick_o,
  output logic machine_cycle_o,
  output logic core_rst_o,
  output logic io_pullup_o,
  output logic init_start_o,
  output logic rst_pin_o,
  output logic rst_pin_oe_o,
  output logic [6:0] converter_ctrl_fields_o
);

  // Derived counts
  localparam int SG_CYC =
    (`OCR_SG_MIN_PERIOD_NS + `OCR_CLK_PERIOD_NS - 1) / `OCR_CLK_PERIOD_NS;
  localparam int WAIT_CYC = STARTUP_CYC + `OCR_INSTR_AUX_TICKS * AUX_CYC;
  localparam int AW = $clog2(AUX_CYC + 1);
  localparam int SW = $clog2(SG_CYC + 1);
  localparam int WW = $clog2(WAIT_CYC + 1);
  localparam int RW = $clog2(RST_DLY_TICKS + 1);

  // Aux period below safeguard spacing would shorten pulses
  if (AUX_CYC < SG_CYC || STARTUP_CYC < 1 || RST_DLY_TICKS < 1) begin : g_chk
    $error("ocr_top: parameter out of range");
  end

  ////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////
  logic main_q;
  logic [SW-1:0] sg_cnt;
  logic [AW-1:0] aux_cnt;
  logic edge_seen;
  logic main_lost;
  ocr_src_t src;
  ocr_src_t next_src;
  logic [WW-1:0] wait_cnt;
  logic [1:0] div_cnt;
  logic [1:0] div_sel;
  logic [7:0] conv_ctrl;
  ocr_rst_t rst_st;
  ocr_rst_t next_rst_st;
  logic [RW-1:0] dly_cnt;
  logic [3:0] sub_cnt [2];
  logic [1:0] sub_hit;

  ////////////////////////////////////////////////////////////
  // Main oscillator edges and safeguard filter
  ////////////////////////////////////////////////////////////
  wire main_raw = main_osc_i & ~main_q;
  wire sg_open = (sg_cnt == '0) | ~SAFEGUARD_EN;
  wire main_acc = main_raw & sg_open;
  wire main_edge = main_acc & main_osc_en_o;

  // Edge sampler and spacing counter
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_q <= 1'b0;
      sg_cnt <= '0;
    end else begin
      main_q <= main_osc_i;
      if (main_acc) begin
        sg_cnt <= SW'(SG_CYC - 1);
      end else if (sg_cnt != '0) begin
        sg_cnt <= sg_cnt - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Auxiliary timebase and missing edge detector
  ////////////////////////////////////////////////////////////
  wire aux_tick = (aux_cnt == '0);
  wire aux_clk_tick = aux_tick & SAFEGUARD_EN;
  wire next_lost = aux_tick ? ~(edge_seen | main_edge) : main_lost;
  // no aux tick right after a main one
  wire to_aux = (src == OCR_SRC_MAIN) & (next_src == OCR_SRC_AUX);

  // Auxiliary period counter and gap flag
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_cnt <= '0;
      edge_seen <= 1'b0;
      main_lost <= 1'b1;
    end else begin
      aux_cnt <= (aux_tick | to_aux) ? AW'(AUX_CYC - 1) : aux_cnt - 1'b1;
      edge_seen <= aux_tick ? 1'b0 : (edge_seen | main_edge);
      main_lost <= next_lost;
    end
  end

  ////////////////////////////////////////////////////////////
  // Clock source selection
  ////////////////////////////////////////////////////////////
  wire in_reset = (rst_st != OCR_RST_RUN);
  // off bit only acts with safeguard
  wire osc_off = SAFEGUARD_EN & conv_ctrl[`OCR_OSC_OFF_BIT];
  // any reset overrides the off bit
  wire next_main_en = in_reset | (~osc_off & ~stop_mode_i);

  // Source state machine
  always_comb begin
    next_src = src;
    case (src)
      OCR_SRC_MAIN: begin
        // fall back on stop or loss
        if (SAFEGUARD_EN && (main_lost || !main_osc_en_o) && !main_edge) begin
          next_src = OCR_SRC_AUX;
        end
      end
      OCR_SRC_AUX: begin
        if (!SAFEGUARD_EN) begin
          next_src = OCR_SRC_MAIN;
        end else if (main_osc_en_o) begin
          next_src = OCR_SRC_WAIT;
        end
      end
      OCR_SRC_WAIT: begin
        // take over on a main edge
        if (!main_osc_en_o) begin
          next_src = OCR_SRC_AUX;
        end else if (wait_cnt == '0 && !main_lost
                     && main_edge && !aux_clk_tick) begin
          next_src = OCR_SRC_MAIN;
        end
      end
      default: next_src = OCR_SRC_AUX;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt <= WW'(WAIT_CYC);
    end else if (src != OCR_SRC_WAIT) begin
      wait_cnt <= WW'(WAIT_CYC);
    end else if (wait_cnt != '0) begin
      wait_cnt <= wait_cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src <= OCR_SRC_AUX;
      main_osc_en_o <= 1'b1;
      aux_osc_en_o <= SAFEGUARD_EN;
      on_aux_o <= SAFEGUARD_EN;
    end else begin
      src <= next_src;
      main_osc_en_o <= next_main_en;
      aux_osc_en_o <= SAFEGUARD_EN & (next_src != OCR_SRC_MAIN);
      on_aux_o <= SAFEGUARD_EN & (next_src != OCR_SRC_MAIN);
    end
  end

  ////////////////////////////////////////////////////////////
  // Oscillator divider
  ////////////////////////////////////////////////////////////
  // one tick source at a time
  wire osc_tick = (src == OCR_SRC_MAIN) ? main_edge : aux_clk_tick;
  wire [1:0] div_last = (div_sel == 2'h0) ? 2'h0 :
                        (div_sel == 2'h1) ? 2'h1 : 2'h3;
  wire div_wrap = (div_cnt >= div_last);
  wire int_tick = osc_tick & div_wrap;

  // Divider counter and internal tick
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 2'h0;
      int_clk_tick_o <= 1'b0;
    end else begin
      if (osc_tick) begin
        div_cnt <= div_wrap ? 2'h0 : div_cnt + 2'h1;
      end
      int_clk_tick_o <= int_tick;
    end
  end

  ////////////////////////////////////////////////////////////
  // Peripheral and machine cycle dividers
  ////////////////////////////////////////////////////////////
  for (genvar g = 0; g < 2; g++) begin : g_sub
    localparam logic [3:0] LAST = (g == 0) ?
      4'(`OCR_TMR_DIV - 1) : 4'(`OCR_CORE_DIV - 1);
    assign sub_hit[g] = int_tick & (sub_cnt[g] == LAST);
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        sub_cnt[g] <= 4'h0;
      end else if (sub_hit[g] || in_reset) begin
        sub_cnt[g] <= 4'h0;
      end else if (int_tick) begin
        sub_cnt[g] <= sub_cnt[g] + 4'h1;
      end
    end
  end

  // Registered divider pulses
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      periph_tick_o <= 1'b0;
      machine_cycle_o <= 1'b0;
    end else begin
      periph_tick_o <= sub_hit[0];
      machine_cycle_o <= sub_hit[1];
    end
  end

  ////////////////////////////////////////////////////////////
  // Reset sequencer
  ////////////////////////////////////////////////////////////
  // four reset sources
  wire int_src = por_i | wdg_timeout_i | low_voltage_detect_i;
  wire any_src = int_src | ~rst_pin_n_i;
  wire dly_done = (dly_cnt == '0) & osc_tick;

  // Sequencer state machine
  always_comb begin
    next_rst_st = rst_st;
    case (rst_st)
      OCR_RST_HOLD: begin
        if (!any_src) begin
          next_rst_st = OCR_RST_DELAY;
        end
      end
      OCR_RST_DELAY: begin
        if (any_src) begin
          next_rst_st = OCR_RST_HOLD;
        end else if (dly_done) begin
          next_rst_st = OCR_RST_RUN;
        end
      end
      OCR_RST_RUN: begin
        if (any_src) begin
          next_rst_st = OCR_RST_HOLD;
        end
      end
      default: next_rst_st = OCR_RST_HOLD;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_cnt <= RW'(RST_DLY_TICKS - 1);
    end else if (rst_st != OCR_RST_DELAY) begin
      dly_cnt <= RW'(RST_DLY_TICKS - 1);
    end else if (osc_tick && dly_cnt != '0) begin
      dly_cnt <= dly_cnt - 1'b1;
    end
  end

  // Sequencer state and reset outputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_st <= OCR_RST_HOLD;
      core_rst_o <= 1'b1;
      io_pullup_o <= 1'b1;
      init_start_o <= 1'b0;
      rst_pin_o <= 1'b0;
      rst_pin_oe_o <= 1'b0;
    end else begin
      rst_st <= next_rst_st;
      core_rst_o <= (next_rst_st != OCR_RST_RUN);
      io_pullup_o <= (next_rst_st != OCR_RST_RUN);
      init_start_o <= (rst_st == OCR_RST_DELAY) &
                      (next_rst_st == OCR_RST_RUN);
      rst_pin_o <= 1'b0;
      // pin pulled low by internal source
      rst_pin_oe_o <= int_src;
    end
  end

  ////////////////////////////////////////////////////////////
  // APB register slave
  ////////////////////////////////////////////////////////////
  wire acc = psel_i & penable_i;
  wire in_page = (paddr_i[11:10] == 2'h0);
  wire hit_conv = in_page & (paddr_i[9:2] == `OCR_IDX_CONV_CTRL);
  wire hit_div = in_page & (paddr_i[9:2] == `OCR_IDX_DIV_CTRL);
  wire hit_stat = in_page & (paddr_i[9:2] == `OCR_IDX_STATUS);
  wire hit = hit_conv | hit_div | hit_stat;
  wire wr = acc & pready_o & pwrite_i;
  wire [7:0] stat;
  wire [31:0] rd_data;

  // Status word
  assign stat[`OCR_STAT_ON_AUX] = on_aux_o;
  assign stat[`OCR_STAT_LOST] = main_lost;
  assign stat[`OCR_STAT_MAIN_EN] = main_osc_en_o;
  assign stat[`OCR_STAT_IN_RST] = in_reset;
  assign stat[`OCR_STAT_SG] = SAFEGUARD_EN;
  assign stat[7:5] = 3'h0;

  assign rd_data = hit_conv ? {24'h0, conv_ctrl} :
                   hit_stat ? {24'h0, stat} : 32'h0;

  // Answer one cycle into the access phase
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
      converter_ctrl_fields_o <= 7'h0;
    end else begin
      pready_o <= acc & ~pready_o;
      prdata_o <= (acc & ~pready_o & ~pwrite_i) ? rd_data : 32'h0;
      pslverr_o <= acc & ~pready_o & ~hit;
      converter_ctrl_fields_o <= {conv_ctrl[7:3], conv_ctrl[1:0]};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      conv_ctrl <= `OCR_CONV_CTRL_RST;
      div_sel <= `OCR_DIV_CTRL_RST;
    end else if (in_reset) begin
      conv_ctrl <= `OCR_CONV_CTRL_RST;
      div_sel <= `OCR_DIV_CTRL_RST;
    end else begin
      if (wr && hit_conv) begin
        conv_ctrl <= pwdata_i[7:0];
      end
      if (wr && hit_div) begin
        div_sel <= pwdata_i[1:0];
      end
    end
  end

endmodule

// *** ocr_cfg.svh ***
`ifndef OCR_CFG_SVH
`define OCR_CFG_SVH
// Register word indices; byte address is four times the index
`define OCR_IDX_CONV_CTRL 8'hD1
`define OCR_IDX_DIV_CTRL 8'hDC
`define OCR_IDX_STATUS 8'hF0
// Reset values
`define OCR_CONV_CTRL_RST 8'h40
`define OCR_DIV_CTRL_RST 2'h0
// Field positions
`define OCR_OSC_OFF_BIT 2
`define OCR_STAT_ON_AUX 0
`define OCR_STAT_LOST 1
`define OCR_STAT_MAIN_EN 2
`define OCR_STAT_IN_RST 3
`define OCR_STAT_SG 4
// Timing, in ns, and derived counts
`define OCR_CLK_PERIOD_NS 10
`define OCR_AUX_PERIOD_NS 4000
`define OCR_OSC_STARTUP_NS 100000
`define OCR_SG_MIN_PERIOD_NS 125
`define OCR_INSTR_AUX_TICKS 65
`define OCR_RST_DLY_TICKS 2048
`define OCR_TMR_DIV 12
`define OCR_CORE_DIV 13
`endif

// *** ocr_pkg.sv ***
package ocr_pkg;

  // Core clock source
  typedef enum logic [1:0] {
    OCR_SRC_AUX,
    OCR_SRC_WAIT,
    OCR_SRC_MAIN
  } ocr_src_t;

  // Reset sequencer
  typedef enum logic [1:0] {
    OCR_RST_HOLD,
    OCR_RST_DELAY,
    OCR_RST_RUN
  } ocr_rst_t;

endpackage

// *** ocr_osc_model.sv ***
`timescale 1ns/1ps
module ocr_osc_model (
  input wire logic clk_i,
  input wire logic osc_en_i,
  input wire logic fail_i,
  input wire logic [3:0] half_i,
  input wire logic ext_rst_i,
  input wire logic pin_oe_i,
  output logic osc_o,
  output logic pin_n_o
);
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    osc_o = 1'b0;
  end
  // Element toggles every half_i cycles; a dead or disabled one stands still
  always @(posedge clk_i) begin
    if (!osc_en_i || fail_i) begin
      cnt <= 4'h0;
    end else if (cnt + 4'h1 >= half_i) begin
      cnt <= 4'h0;
      osc_o <= !osc_o;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  // Pin has a pull-up; board or device pulls it low
  assign pin_n_o = !(ext_rst_i || pin_oe_i);
endmodule

// *** ocr_top_props.sv ***
`timescale 1ns/1ps
module ocr_top_props
  import ocr_pkg::*;
#(
  parameter bit SAFEGUARD_EN = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic stop_mode_i,
  input wire logic rst_pin_n_i,
  input wire logic por_i,
  input wire logic wdg_timeout_i,
  input wire logic low_voltage_detect_i,
  input wire logic main_osc_en_o,
  input wire logic aux_osc_en_o,
  input wire logic on_aux_o,
  input wire logic int_clk_tick_o,
  input wire logic core_rst_o,
  input wire logic init_start_o,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_o,
  input wire logic [6:0] converter_ctrl_fields_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Completed converter register write outside reset
  wire conv_wr = psel_i & penable_i & pready_o & pwrite_i & !core_rst_o
    & (paddr_i == 12'h344);
  wire int_src = por_i | wdg_timeout_i | low_voltage_detect_i;
  logic [6:0] exp_fields;
  // Fields of the last converter write
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exp_fields <= 7'h00;
    end else if (conv_wr) begin
      exp_fields <= {pwdata_i[7:3], pwdata_i[1:0]};
    end
  end
  sequence s_conv_off;
    conv_wr && pwdata_i[2] && SAFEGUARD_EN;
  endsequence
  sequence s_main_stops;
    ##[1:3] !main_osc_en_o;
  endsequence
  property p_osc_off;
    s_conv_off |-> s_main_stops;
  endproperty
  a_osc_off: assert property (p_osc_off)
    else $error("main oscillator not stopped");
  property p_aux_on;
    $fell(main_osc_en_o) && !stop_mode_i && !core_rst_o
      |-> ##[1:3] on_aux_o && aux_osc_en_o;
  endproperty
  a_aux_on: assert property (p_aux_on)
    else $error("auxiliary clock not taken");
  property p_reset_main;
    core_rst_o && $past(core_rst_o) |-> main_osc_en_o;
  endproperty
  a_reset_main: assert property (p_reset_main)
    else $error("main oscillator off in reset");
  property p_aux_off;
    $fell(on_aux_o) |-> ##[0:2] !aux_osc_en_o;
  endproperty
  a_aux_off: assert property (p_aux_off)
    else $error("auxiliary oscillator left running");
  property p_fields;
    conv_wr |-> ##2 converter_ctrl_fields_o == exp_fields;
  endproperty
  a_fields: assert property (p_fields)
    else $error("converter fields wrong");
  property p_gap;
    int_clk_tick_o |=> (!int_clk_tick_o)[*8] ##1 (!int_clk_tick_o)[*4];
  endproperty
  a_gap: assert property (p_gap)
    else $error("internal clock too fast");
  property p_pin;
    !rst_pin_n_i |=> core_rst_o;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin low without reset");
  property p_init;
    init_start_o |-> !core_rst_o ##1 !init_start_o;
  endproperty
  a_init: assert property (p_init)
    else $error("init pulse malformed");
  property p_rst_pin;
    int_src |=> rst_pin_oe_o && !rst_pin_o;
  endproperty
  a_rst_pin: assert property (p_rst_pin)
    else $error("reset pin not driven low");
  property p_pready;
    psel_i && $rose(penable_i) |-> !pready_o ##1 pready_o;
  endproperty
  a_pready: assert property (p_pready)
    else $error("bus answer timing wrong");
endmodule
bind ocr_top ocr_top_props #(
  .SAFEGUARD_EN(SAFEGUARD_EN)
) u_props (
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .pready_o(pready_o),
  .stop_mode_i(stop_mode_i),
  .rst_pin_n_i(rst_pin_n_i),
  .por_i(por_i),
  .wdg_timeout_i(wdg_timeout_i),
  .low_voltage_detect_i(low_voltage_detect_i),
  .main_osc_en_o(main_osc_en_o),
  .aux_osc_en_o(aux_osc_en_o),
  .on_aux_o(on_aux_o),
  .int_clk_tick_o(int_clk_tick_o),
  .core_rst_o(core_rst_o),
  .init_start_o(init_start_o),
  .rst_pin_o(rst_pin_o),
  .rst_pin_oe_o(rst_pin_oe_o),
  .converter_ctrl_fields_o(converter_ctrl_fields_o)
);

// *** ocr_top_bench.sv ***
`timescale 1ns/1ps
module ocr_top_bench;
  import ocr_pkg::*;
  localparam int AUX = 40;
  localparam int STUP = 20;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, stop = 1'b0, fail = 1'b0, ext = 1'b0, e, osc, pin_n;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q;
  logic [2:0] src = 3'h0;
  logic [3:0] half = 4'h8;
  logic [1:0] div_image = 2'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, main_osc_en_o, aux_osc_en_o, on_aux_o;
  logic int_clk_tick_o, periph_tick_o, machine_cycle_o, core_rst_o;
  logic io_pullup_o, init_start_o, rst_pin_o, rst_pin_oe_o;
  logic [6:0] fields;
  int bad_count = 0, num_checks = 0, c;
  int ratio[4] = '{1, 2, 4, 4};
  ocr_top #(.AUX_CYC(AUX), .STARTUP_CYC(STUP), .RST_DLY_TICKS(4)) dut (
    .core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .main_osc_i(osc), .stop_mode_i(stop),
    .rst_pin_n_i(pin_n), .por_i(src[0]), .wdg_timeout_i(src[1]),
    .low_voltage_detect_i(src[2]), .main_osc_en_o(main_osc_en_o),
    .aux_osc_en_o(aux_osc_en_o), .on_aux_o(on_aux_o),
    .int_clk_tick_o(int_clk_tick_o), .periph_tick_o(periph_tick_o),
    .machine_cycle_o(machine_cycle_o), .core_rst_o(core_rst_o),
    .io_pullup_o(io_pullup_o), .init_start_o(init_start_o),
    .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
    .converter_ctrl_fields_o(fields));
  ocr_osc_model u_osc (.clk_i(clk), .osc_en_i(main_osc_en_o),
    .fail_i(fail), .half_i(half), .ext_rst_i(ext),
    .pin_oe_i(rst_pin_oe_o), .osc_o(osc), .pin_n_o(pin_n));
  // Clock
  initial begin
    forever #5 clk = !clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One bus transfer: setup, access, hold until pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    q = prdata_o;
    e = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      $display("mismatch at %0t: no bus answer", $time);
      end_sim();
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return init_start_o;
      1: return on_aux_o;
      2: return int_clk_tick_o;
      3: return periph_tick_o;
      default: return machine_cycle_o;
    endcase
  endfunction
  // Bounded wait for a level, counting cycles
  task automatic wait_sig(input int s, input logic v, input int lim);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (sig(s) !== v && c < lim);
    if (c >= lim) begin
      bad_count++;
      $display("mismatch at %0t: wait ran out", $time);
      end_sim();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wait_sig(0, 1'b1, 5000);
    chk(core_rst_o, 1'b0);
    wait_sig(1, 1'b0, 5000);
    apb(0, 12'h344, 0); chk(q, 32'h40);
    apb(0, 12'h370, 0); chk(q, 32'h0);
    apb(0, 12'h3C0, 0); chk(q[4], 1'b1);
    apb(0, 12'h100, 0); chk(e, 1'b1);
    apb(1, 12'h344, 32'hFB);
    repeat (3) @(posedge clk);
    chk(fields, 7'h7F);
    chk(main_osc_en_o, 1'b1);
    $display("registers done");
    wait_sig(3, 1'b1, 1000); wait_sig(3, 1'b1, 1000);
    chk(c, 192);
    wait_sig(4, 1'b1, 1000); wait_sig(4, 1'b1, 1000);
    chk(c, 208);
    for (int k = 0; k < 4; k++) begin
      div_image = k[1:0];
      apb(1, 12'h370, {30'h0, div_image});
      repeat (3) wait_sig(2, 1'b1, 1000);
      chk(c, 16 * ratio[k]);
    end
    apb(1, 12'h370, 0);
    half <= 4'h2;
    repeat (3) wait_sig(2, 1'b1, 1000);
    chk(c, 16);
    half <= 4'h8;
    $display("divider done");
    apb(1, 12'h344, 32'h44);
    repeat (4) @(posedge clk);
    chk({main_osc_en_o, on_aux_o, aux_osc_en_o}, 3'b011);
    apb(0, 12'h3C0, 0); chk({q[2], q[0]}, 2'b01);
    apb(1, 12'h344, 32'h40);
    wait_sig(1, 1'b0, 5000);
    chk(c >= STUP + 65 * AUX, 1'b1);
    repeat (3) @(posedge clk);
    chk({main_osc_en_o, aux_osc_en_o}, 2'b10);
    $display("oscillator off done");
    stop <= 1'b1;
    repeat (4) @(posedge clk);
    chk(main_osc_en_o, 1'b0);
    ext <= 1'b1;
    repeat (3) @(posedge clk);
    chk({main_osc_en_o, io_pullup_o, core_rst_o}, 3'b111);
    ext <= 1'b0;
    stop <= 1'b0;
    wait_sig(0, 1'b1, 5000); chk(core_rst_o, 1'b0);
    ext <= 1'b1;
    @(posedge clk);
    ext <= 1'b0;
    repeat (2) @(posedge clk);
    chk({core_rst_o, io_pullup_o}, 2'b11);
    wait_sig(0, 1'b1, 5000); chk(core_rst_o, 1'b0);
    for (int s = 0; s < 3; s++) begin
      src <= 3'h1 << s;
      repeat (3) @(posedge clk);
      chk({rst_pin_oe_o, rst_pin_o, core_rst_o}, 3'b101);
      src <= 3'h0;
      wait_sig(0, 1'b1, 5000);
    end
    $display("reset done");
    wait_sig(1, 1'b0, 5000);
    fail <= 1'b1;
    wait_sig(1, 1'b1, 140);
    apb(0, 12'h3C0, 0); chk(q[1:0], 2'b11);
    $display("failover done");
    end_sim();
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule
